// *** src/flash_status_protect.sv ***
// Status register, write latch, busy timing and write protection of the serial flash
module flash_status_protect #(
    parameter int PROG_CYCLES = flash_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = flash_pkg::ERASE_CYCLES,
    parameter int STATUS_WRITE_CYCLES = flash_pkg::STATUS_WRITE_CYCLES
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    // Nonvolatile copy of lock and protect bits
    input wire logic [7:0] nv_image,
    output logic nv_store,
    output logic [7:0] nv_data,
    // Array operation start
    output logic op_start,
    output flash_pkg::array_op_t op_kind,
    output logic [flash_pkg::ADDR_W-1:0] op_addr,
    output logic busy
);
    spi_link_if link ();

    logic [7:0] opcode_r;
    logic [23:0] addr_r;
    logic [7:0] wdata_r;
    logic latch_r;
    logic [2:0] prot_r;
    logic lock_r;
    logic [flash_pkg::TMR_W-1:0] tmr_r;
    logic [7:0] status_word;
    logic [flash_pkg::ADDR_W-1:0] addr17;
    logic exec;
    logic wr_ok;
    logic is_set;
    logic is_clr;
    logic is_wsr;
    logic st_wr_ok;
    logic prog_ok;
    logic sec_ok;
    logic blk_ok;
    logic chip_ok;
    logic start;
    logic done;
    flash_pkg::array_op_t kind_nxt;
    logic [flash_pkg::ADDR_W-1:0] addr_nxt;
    logic [flash_pkg::TMR_W-1:0] tmr_nxt;

    spi_shifter u_shift (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .wp_n(wp_n),
        .so(so),
        .so_oe(so_oe),
        .link(link)
    );

    function automatic logic prot_hit_f(input logic [2:0] bp, input logic [flash_pkg::ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        case (bp[1:0])
            flash_pkg::PROT_NONE: hit = 1'b0;
            flash_pkg::PROT_QUARTER: hit = (a >= flash_pkg::QUARTER_BASE);
            flash_pkg::PROT_HALF: hit = (a >= flash_pkg::HALF_BASE);
            default: hit = 1'b1;
        endcase
        // Top select bit protects everything at this density
        return hit | bp[2];
    endfunction

    // ==========================================================
    // Status word and read path
    always_comb begin
        status_word = flash_pkg::STATUS_RESET;
        status_word[flash_pkg::BUSY_BIT] = busy;
        status_word[flash_pkg::LATCH_BIT] = latch_r;
        status_word[flash_pkg::PROT_HI:flash_pkg::PROT_LO] = prot_r;
        status_word[flash_pkg::LOCK_BIT] = lock_r;
    end

    assign link.tx_byte = status_word;
    assign link.tx_en = (opcode_r == flash_pkg::OP_STATUS_READ) && (link.byte_cnt >= flash_pkg::LEN_SHORT);

    // ==========================================================
    // Instruction capture
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            opcode_r <= 8'h00;
            addr_r <= 24'h000000;
            wdata_r <= 8'h00;
        end else if (ce && link.rx_valid) begin
            if (link.byte_cnt == flash_pkg::IDX_OPCODE) begin
                opcode_r <= link.rx_byte;
            end
            if (link.byte_cnt >= flash_pkg::IDX_ADDR_FIRST && link.byte_cnt <= flash_pkg::IDX_ADDR_LAST) begin
                addr_r <= {addr_r[15:0], link.rx_byte};
            end
            if (link.byte_cnt == flash_pkg::IDX_STATUS_DATA) begin
                wdata_r <= link.rx_byte;
            end
        end else if (ce && link.frame_start) begin
            // A new frame never inherits the previous opcode
            opcode_r <= 8'h00;
        end
    end

    // ==========================================================
    // Acceptance; partial bytes at deselect cancel the instruction
    assign exec = link.frame_end & link.aligned;
    assign addr17 = addr_r[flash_pkg::ADDR_W-1:0];
    assign wr_ok = latch_r & ~busy;
    assign is_set = (opcode_r == flash_pkg::OP_LATCH_SET) && (link.byte_cnt == flash_pkg::LEN_SHORT);
    assign is_clr = (opcode_r == flash_pkg::OP_LATCH_CLEAR) && (link.byte_cnt == flash_pkg::LEN_SHORT);
    assign is_wsr = (opcode_r == flash_pkg::OP_STATUS_WRITE) && (link.byte_cnt == flash_pkg::LEN_STATUS_WRITE);
    assign st_wr_ok = exec & is_wsr & wr_ok & ~(lock_r & ~link.wp_level);
    assign prog_ok = exec & wr_ok & ~prot_hit_f(prot_r, addr17) &
        (opcode_r == flash_pkg::OP_PAGE_PROG) & (link.byte_cnt >= flash_pkg::LEN_PROG_MIN);
    assign sec_ok = exec & wr_ok & ~prot_hit_f(prot_r, addr17) & (link.byte_cnt == flash_pkg::LEN_ERASE) &
        ((opcode_r == flash_pkg::OP_SECTOR_ERASE_A) | (opcode_r == flash_pkg::OP_SECTOR_ERASE_B));
    assign blk_ok = exec & wr_ok & ~prot_hit_f(prot_r, addr17) & (link.byte_cnt == flash_pkg::LEN_ERASE) &
        (opcode_r == flash_pkg::OP_BLOCK_ERASE);
    assign chip_ok = exec & wr_ok & (prot_r == 3'h0) & (link.byte_cnt == flash_pkg::LEN_SHORT) &
        ((opcode_r == flash_pkg::OP_FULL_ERASE_A) | (opcode_r == flash_pkg::OP_FULL_ERASE_B));
    assign start = st_wr_ok | prog_ok | sec_ok | blk_ok | chip_ok;
    assign done = busy & (tmr_r == flash_pkg::TMR_ONE);

    always_comb begin
        kind_nxt = flash_pkg::OP_PROGRAM;
        addr_nxt = addr17;
        tmr_nxt = flash_pkg::TMR_W'(PROG_CYCLES);
        if (st_wr_ok) begin
            kind_nxt = flash_pkg::OP_STATUS;
            tmr_nxt = flash_pkg::TMR_W'(STATUS_WRITE_CYCLES);
        end else if (sec_ok) begin
            kind_nxt = flash_pkg::OP_SECTOR;
            addr_nxt = {addr17[flash_pkg::ADDR_W-1:flash_pkg::SECTOR_W], {flash_pkg::SECTOR_W{1'b0}}};
            tmr_nxt = flash_pkg::TMR_W'(ERASE_CYCLES);
        end else if (blk_ok) begin
            kind_nxt = flash_pkg::OP_BLOCK;
            addr_nxt = {addr17[flash_pkg::ADDR_W-1:flash_pkg::BLOCK_W], {flash_pkg::BLOCK_W{1'b0}}};
            tmr_nxt = flash_pkg::TMR_W'(ERASE_CYCLES);
        end else if (chip_ok) begin
            kind_nxt = flash_pkg::OP_CHIP;
            addr_nxt = '0;
            tmr_nxt = flash_pkg::TMR_W'(ERASE_CYCLES);
        end
    end

    // ==========================================================
    // Operation timer and busy flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            tmr_r <= '0;
            op_start <= 1'b0;
            op_kind <= flash_pkg::OP_PROGRAM;
            op_addr <= '0;
        end else if (ce) begin
            op_start <= start;
            if (start) begin
                busy <= 1'b1;
                tmr_r <= tmr_nxt;
                op_kind <= kind_nxt;
                op_addr <= addr_nxt;
            end else if (done) begin
                busy <= 1'b0;
                tmr_r <= '0;
            end else if (busy) begin
                tmr_r <= tmr_r - flash_pkg::TMR_ONE;
            end
        end
    end

    // ==========================================================
    // Write latch: a set in the completion cycle wins over the auto clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            latch_r <= 1'b0;
        end else if (ce) begin
            if (exec && is_set) begin
                latch_r <= 1'b1;
            end else if ((exec && is_clr) || done) begin
                latch_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Lock and protect bits; reset reloads them from the nonvolatile copy
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prot_r <= nv_image[flash_pkg::PROT_HI:flash_pkg::PROT_LO];
            lock_r <= nv_image[flash_pkg::LOCK_BIT];
            nv_store <= 1'b0;
            nv_data <= flash_pkg::STATUS_RESET;
        end else if (ce) begin
            nv_store <= st_wr_ok;
            if (st_wr_ok) begin
                prot_r <= wdata_r[flash_pkg::PROT_HI:flash_pkg::PROT_LO];
                lock_r <= wdata_r[flash_pkg::LOCK_BIT];
                nv_data <= wdata_r & flash_pkg::NV_MASK;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !ce);

    sequence wsr_unlocked;
        exec && is_wsr && latch_r && !busy && (!lock_r || link.wp_level);
    endsequence
    sequence wsr_applied;
        nv_store && busy && op_kind == flash_pkg::OP_STATUS ##1 busy;
    endsequence

    status_write_ok_a: assert property (wsr_unlocked |=> wsr_applied)
        else $error("unlocked status write not applied");
    lock_free_a: assert property (exec && is_wsr && latch_r && !busy && !lock_r |=> nv_store)
        else $error("status write refused with lock bit clear");
    hw_lock_a: assert property (exec && is_wsr && lock_r && !link.wp_level |=> !nv_store ##1 $stable(prot_r))
        else $error("locked status register changed");
    unlatched_a: assert property (exec && !latch_r |=> !op_start && !nv_store)
        else $error("operation started without write latch");
    latch_set_a: assert property (exec && is_set |=> latch_r)
        else $error("latch set instruction ignored");
    latch_clear_a: assert property (exec && is_clr |=> !latch_r)
        else $error("latch clear instruction ignored");
    done_clear_a: assert property (done && !(exec && is_set) |=> !busy && !latch_r)
        else $error("completion did not clear busy and latch");
    region_guard_a: assert property (op_start && op_kind != flash_pkg::OP_STATUS
        |-> !prot_hit_f(prot_r, op_addr))
        else $error("operation started in protected area");
    full_erase_a: assert property (op_start && op_kind == flash_pkg::OP_CHIP |-> prot_r == 3'h0)
        else $error("full erase with protection set");
    busy_hold_a: assert property (busy && !done |=> !op_start)
        else $error("operation started while busy");
    nv_only_wsr_a: assert property ($changed(prot_r) || $changed(lock_r) |-> nv_store)
        else $error("protect bits changed without status write");
    busy_runs_a: assert property (op_start |-> busy ##1 busy)
        else $error("busy flag not raised for operation");
endmodule

// *** src/flash_pkg.sv ***
// Constants, encodings and timing for the serial flash status and protection block
// Behaviour
// - Busy flag is read-only; 1 while program, erase or status write runs.
// - Status write, program and all erases refused while the write latch is 0.
// - Latch-set instruction sets the write latch.
// - Latch-clear instruction clears the write latch.
// - Write latch clears itself when a status write, program or erase completes.
// - Protect select bits choose a protected area; program or erase there is inhibited.
// - Full array erase runs only when all three protect select bits are 0.
// - With the lock bit 0, status writes are accepted whatever the protect pin.
// - Lock bit 1 with protect pin low makes lock and protect bits read-only.
// - Lock bit 1 with protect pin high still lets status writes update.
// - Protect and lock bits persist over power cycles; only status writes change them.
// - Status read returns all eight status bits including busy and latch.
// - Protect and lock bits start at 0 from the factory.
// - Uniform 4 KB sectors grouped in 32 KB blocks set erase and protect granularity.
// - Input bits sampled on serial clock rise, output driven from its fall.
package flash_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_KHZ = 20000;
    localparam int PROG_TIME_MS = 2;
    localparam int ERASE_TIME_MS = 10;
    localparam int STATUS_WRITE_TIME_MS = 5;
    localparam int PROG_CYCLES = PROG_TIME_MS * CLK_KHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * CLK_KHZ;
    localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_MS * CLK_KHZ;
    localparam int TMR_W = 18;
    // ==========================================================
    // Instruction codes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE_A = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERASE_B = 8'hd7;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
    localparam logic [7:0] OP_FULL_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_FULL_ERASE_B = 8'h60;
    // ==========================================================
    // Byte positions in a frame, counted from 1
    localparam logic [2:0] IDX_OPCODE = 3'h1;
    localparam logic [2:0] IDX_ADDR_FIRST = 3'h2;
    localparam logic [2:0] IDX_ADDR_LAST = 3'h4;
    localparam logic [2:0] IDX_STATUS_DATA = 3'h2;
    localparam logic [2:0] LEN_SHORT = 3'h1;
    localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
    localparam logic [2:0] LEN_ERASE = 3'h4;
    localparam logic [2:0] LEN_PROG_MIN = 3'h5;
    localparam logic [2:0] LEN_MAX = 3'h7;
    // ==========================================================
    // Status register layout
    localparam int BUSY_BIT = 0;
    localparam int LATCH_BIT = 1;
    localparam int PROT_LO = 2;
    localparam int PROT_HI = 4;
    localparam int LOCK_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] NV_MASK = 8'h9c;
    // ==========================================================
    // Array map and protected areas
    localparam int ADDR_W = 17;
    localparam int SECTOR_W = 12;
    localparam int BLOCK_W = 15;
    localparam logic [ADDR_W-1:0] QUARTER_BASE = 17'h18000;
    localparam logic [ADDR_W-1:0] HALF_BASE = 17'h10000;
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_QUARTER = 2'h1;
    localparam logic [1:0] PROT_HALF = 2'h2;
    localparam logic [TMR_W-1:0] TMR_ONE = 18'h00001;

    typedef enum logic [2:0] {OP_PROGRAM, OP_SECTOR, OP_BLOCK, OP_CHIP, OP_STATUS} array_op_t;
endpackage

// *** src/spi_link_if.sv ***
// Byte-level link between the serial shifter and the status core
interface spi_link_if;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic [2:0] byte_cnt;
    logic frame_start;
    logic frame_end;
    logic aligned;
    logic wp_level;
    logic [7:0] tx_byte;
    logic tx_en;

    modport shifter (
        output rx_byte, rx_valid, byte_cnt, frame_start, frame_end, aligned, wp_level,
        input tx_byte, tx_en
    );
    modport core (
        input rx_byte, rx_valid, byte_cnt, frame_start, frame_end, aligned, wp_level,
        output tx_byte, tx_en
    );
endinterface

// *** src/spi_shifter.sv ***
// Pin synchronisers and serial byte shifter for the flash status block
module spi_shifter (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    // Byte side
    spi_link_if.shifter link
);
    // [0] first stage, [1] second stage, [2] previous second stage for edges
    logic [2:0] sck_q;
    logic [2:0] cs_q;
    logic [1:0] si_q;
    logic [1:0] wp_q;
    logic [2:0] bit_cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_sh_r;
    logic sck_rise;
    logic sck_fall;
    logic sel;
    logic cs_fall;

    // ==========================================================
    // Synchronisers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sck_q <= 3'h0;
            cs_q <= 3'h7;
            si_q <= 2'h0;
            wp_q <= 2'h0;
        end else if (ce) begin
            sck_q <= {sck_q[1:0], sck};
            cs_q <= {cs_q[1:0], cs_n};
            si_q <= {si_q[0], si};
            wp_q <= {wp_q[0], wp_n};
        end
    end

    assign sck_rise = sck_q[1] & ~sck_q[2];
    assign sck_fall = ~sck_q[1] & sck_q[2];
    assign sel = ~cs_q[1];
    assign cs_fall = cs_q[2] & ~cs_q[1];
    assign link.aligned = (bit_cnt_r == 3'h0);
    assign link.wp_level = wp_q[1];

    // ==========================================================
    // Frame edges
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            link.frame_start <= 1'b0;
            link.frame_end <= 1'b0;
        end else if (ce) begin
            link.frame_start <= cs_fall;
            link.frame_end <= ~cs_q[2] & cs_q[1];
        end
    end

    // ==========================================================
    // Receive: MSB first, sampled on the serial clock rise
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bit_cnt_r <= 3'h0;
            sh_r <= 8'h00;
            link.rx_byte <= 8'h00;
            link.rx_valid <= 1'b0;
            link.byte_cnt <= 3'h0;
        end else if (ce) begin
            link.rx_valid <= 1'b0;
            if (cs_fall) begin
                bit_cnt_r <= 3'h0;
                link.byte_cnt <= 3'h0;
            end else if (sel && sck_rise) begin
                sh_r <= {sh_r[6:0], si_q[1]};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7) begin
                    link.rx_byte <= {sh_r[6:0], si_q[1]};
                    link.rx_valid <= 1'b1;
                    // Saturates: only the first bytes of a frame matter here
                    if (link.byte_cnt != flash_pkg::LEN_MAX) begin
                        link.byte_cnt <= link.byte_cnt + 3'h1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Transmit: reload at each byte boundary so a status poll stays fresh
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_sh_r <= 8'h00;
            so <= 1'b0;
            so_oe <= 1'b0;
        end else if (ce) begin
            // The byte count clears on the select edge, so its stale value must not enable the pin
            so_oe <= sel & ~cs_fall & link.tx_en;
            if (sel && sck_fall) begin
                if (bit_cnt_r == 3'h0) begin
                    so <= link.tx_byte[7];
                    tx_sh_r <= {link.tx_byte[6:0], 1'b0};
                end else begin
                    so <= tx_sh_r[7];
                    tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                end
            end
        end
    end

    rx_on_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
        link.rx_valid |-> $past(sck_rise) && $past(sel))
        else $error("byte completed without a serial clock rise");
    oe_in_frame_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
        so_oe |-> $past(sel))
        else $error("output driven outside a frame");
endmodule

// *** test/spi_host_model.sv ***
// Serial host model that frames instructions and samples the status byte
module spi_host_model (
    // Clock
    input wire logic ref_clk,
    // Serial pins
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // ==========================================================
    // One frame, mode 0 or mode 3 as cpol selects, 400 ns serial period, MSB first
    task automatic xfer(input logic [39:0] d, input int n, input logic cpol, output logic [7:0] rd);
        // Idle level moves only while deselected, well ahead of the select edge
        if (sck !== cpol) begin
            sck = cpol;
            repeat (4) @(negedge ref_clk);
        end
        @(negedge ref_clk) cs_n = 1'b0;
        for (int i = 0; i < n * 8; i++) begin
            sck = 1'b0;
            si = d[39-i];
            repeat (4) @(negedge ref_clk);
            sck = 1'b1;
            // An undriven output shows the inverse so a stale bit is caught
            rd = {rd[6:0], (so_oe ? so : ~so)};
            repeat (4) @(negedge ref_clk);
        end
        sck = cpol;
        repeat (4) @(negedge ref_clk);
        cs_n = 1'b1;
        // Deselected input line toggles so a stale bit is never mistaken for data
        si = ~si;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule

// *** test/flash_status_write_protect_tb.sv ***
// Self-checking bench for the flash status and write protection block
module flash_status_write_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wp_n = 1'b1, mode3 = 1'b0;
    logic sck, cs_n, si, so, so_oe, nv_store, op_start, busy;
    logic [7:0] nv_image = 8'h00, nv_data, rd, cur, d;
    logic [16:0] op_addr;
    logic [31:0] lfsr = 32'h00014511, r;
    flash_pkg::array_op_t op_kind;
    int num_errors = 0, check_count = 0, starts = 0;
    bit acc;

    always #25 ref_clk = ~ref_clk;
    // Storage model keeps what the block saves across resets
    always @(posedge ref_clk) begin
        if (nv_store) nv_image <= nv_data;
        if (op_start) starts++;
    end

    flash_status_protect #(.PROG_CYCLES(400), .ERASE_CYCLES(1500), .STATUS_WRITE_CYCLES(400)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .nv_image(nv_image), .nv_store(nv_store), .nv_data(nv_data),
        .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .busy(busy));
    spi_host_model host (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

    // ==========================================================
    // Helpers
    function automatic logic [7:0] exp_status(input logic b, input logic l, input logic [7:0] v);
        return (v & 8'h9c) | {6'h00, l, b};
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rnd();
        lfsr = lfsr_next(lfsr);
        r = lfsr;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [39:0] v, input int n);
        host.xfer(v, n, mode3, rd);
    endtask
    task automatic rd_chk(input logic [7:0] e);
        cmd({8'h05, 32'h0}, 2);
        check(rd, e);
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge ref_clk);
        if (k == 3000) begin
            num_errors++;
            wrap_up();
        end
    endtask
    task automatic wr_status(input logic [7:0] v);
        cmd({8'h06, 32'h0}, 1);
        cmd({8'h01, v, 24'h0}, 2);
    endtask
    task automatic op_chk(input logic [7:0] op, input logic [16:0] a, input int n, input int ok,
                          input flash_pkg::array_op_t kind, input logic [16:0] ea);
        int s0;
        s0 = starts;
        cmd({8'h06, 32'h0}, 1);
        cmd({op, 7'h00, a, 8'h5a}, n);
        check(starts - s0, ok);
        if (ok != 0) begin
            check(op_kind, kind);
            check(op_addr, ea);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd_chk(8'h00);
        $display("reset test done");
        cmd({8'h01, 8'h9c, 24'h0}, 2);
        check(starts, 0);
        cmd({8'h06, 32'h0}, 1);
        rd_chk(8'h02);
        cmd({8'h04, 32'h0}, 1);
        rd_chk(8'h00);
        $display("latch test done");
        wr_status(8'hff);
        check(nv_data, 8'h9c);
        rd_chk(exp_status(1'b1, 1'b1, 8'hff));
        wait_idle();
        rd_chk(8'h9c);
        wp_n = 1'b0;
        wr_status(8'h00);
        rd_chk(8'h9e);
        wp_n = 1'b1;
        wr_status(8'h00);
        wait_idle();
        rd_chk(8'h00);
        cur = 8'h00;
        for (int i = 0; i < 8; i++) begin
            rnd();
            wp_n = r[8];
            mode3 = r[9];
            d = r[7:0];
            acc = !(cur[7] && !wp_n);
            wr_status(d);
            wait_idle();
            if (acc) cur = d & 8'h9c;
            rd_chk(exp_status(1'b0, !acc, cur));
        end
        wp_n = 1'b1;
        mode3 = 1'b0;
        wr_status(8'h04);
        wait_idle();
        $display("status write test done");
        rnd();
        op_chk(8'h02, {2'b11, r[14:0]}, 5, 0, flash_pkg::OP_PROGRAM, 17'h00000);
        op_chk(8'h02, {1'b0, r[15:0]}, 5, 1, flash_pkg::OP_PROGRAM, {1'b0, r[15:0]});
        wait_idle();
        rd_chk(8'h04);
        op_chk(8'h20, {2'b10, r[14:0]}, 4, 1, flash_pkg::OP_SECTOR, {2'b10, r[14:12], 12'h000});
        op_chk(8'hd8, 17'h00000, 4, 0, flash_pkg::OP_BLOCK, 17'h00000);
        wait_idle();
        op_chk(8'hd7, {1'b0, r[15:0]}, 4, 1, flash_pkg::OP_SECTOR, {1'b0, r[15:12], 12'h000});
        wait_idle();
        op_chk(8'hd8, {2'b01, r[14:0]}, 4, 1, flash_pkg::OP_BLOCK, 17'h08000);
        wait_idle();
        op_chk(8'hc7, 17'h00000, 1, 0, flash_pkg::OP_CHIP, 17'h00000);
        rd_chk(8'h06);
        wr_status(8'h00);
        wait_idle();
        op_chk(8'hc7, 17'h00000, 1, 1, flash_pkg::OP_CHIP, 17'h00000);
        wait_idle();
        op_chk(8'h60, 17'h00000, 1, 1, flash_pkg::OP_CHIP, 17'h00000);
        wait_idle();
        $display("protection test done");
        wr_status(8'h98);
        // Enable low must freeze the busy timer for 400 cycles, as long as its whole normal run
        ce = 1'b0;
        repeat (400) @(negedge ref_clk);
        check(busy, 1'b1);
        ce = 1'b1;
        wait_idle();
        @(negedge ref_clk) rst_n = 1'b0;
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd_chk(8'h98);
        $display("persistence test done");
        wrap_up();
    end
endmodule
